// >>> design/pec_defines.svh
`ifndef PEC_DEFINES_SVH
`define PEC_DEFINES_SVH

`define PEC_OFS_PATTERN 8'h00
`define PEC_OFS_RESPONSE 8'h04
`define PEC_OFS_FALL 8'h08
`define PEC_OFS_CMP_COND 8'h0c
`define PEC_OFS_CMP_THR 8'h10
`define PEC_OFS_CLS_COND 8'h14
`define PEC_OFS_CLS_THR 8'h18
`define PEC_OFS_HOLD 8'h1c
`define PEC_OFS_DO_CFG 8'h20
`define PEC_OFS_MONITOR 8'h24
`define PEC_OFS_ERROR 8'h28
`define PEC_OFS_IRQ_ST 8'h2c
`define PEC_OFS_IRQ_MASK 8'h30

`define PEC_CMP_THR_RST 15'h000a
`define PEC_CLS_THR_RST 16'h0000
`define PEC_FUNC_DONE 4'h1
`define PEC_FUNC_CLOSE 4'h2
`define PEC_N_DO 4

`define PEC_IRQ_CLEAR 0
`define PEC_IRQ_DONE 1
`define PEC_IRQ_CLOSE 2

`define PEC_RESP_OKAY 2'h0
`define PEC_RESP_SLVERR 2'h2

`define PEC_MS_NS 1000000
`define PEC_CLK_NS 8
`define PEC_MS_CYCLES (`PEC_MS_NS / `PEC_CLK_NS)

`endif

// >>> design/pec_pkg.sv
package pec_pkg;

	typedef enum logic [0:0] {
		PEC_RAMP_IDLE = 1'b0,
		PEC_RAMP_RUN = 1'b1
	} pec_ramp_e;

	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [1:0] pattern;
		logic [2:0] response;
		logic [15:0] fall_ms;
		logic [1:0] cmp_cond;
		logic [14:0] cmp_thr;
		logic [1:0] cls_cond;
		logic [15:0] cls_thr;
		logic [15:0] hold_ms;
		logic [15:0] do_cfg;
		logic [2:0] irq_st;
		logic [2:0] irq_mask;
		logic irq;
		logic clr_in;
		logic [31:0] offset;
		logic [31:0] err;
		logic [15:0] speed;
		logic [15:0] s0;
		logic [15:0] ramp_f;
		logic [15:0] ramp_ms;
		pec_ramp_e ramp;
		logic [31:0] ms_cnt;
		logic ms_tick;
		logic [15:0] cmp_cnt;
		logic [15:0] cls_cnt;
		logic done;
		logic close;
		logic [3:0] do_q;
	} pec_state_s;

endpackage

// >>> design/pec_error_clear.sv
`timescale 1ns/10ps
`include "pec_defines.svh"

module pec_error_clear import pec_pkg::*; #(
	parameter int MS_CYCLES = `PEC_MS_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [31:0] pos_command_i,
	input wire logic [31:0] pos_feedback_i,
	input wire logic [15:0] speed_command_i,
	input wire logic [15:0] position_mode_speed_command_i,
	input wire logic [15:0] filtered_position_speed_command_i,
	input wire logic error_clear_input_i,
	input wire logic position_mode_i,
	input wire logic running_i,
	output logic [31:0] position_error_value_o,
	output logic [15:0] speed_out_o,
	output logic completed_o,
	output logic close_o,
	output logic [`PEC_N_DO-1:0] do_terminal_o,
	output logic irq_o
);

	pec_state_s q, d;
	logic [`PEC_N_DO-1:0] do_w;
	logic clr_w;
	logic [31:0] diff_w;

	function automatic logic [31:0] reg_read(input logic [7:0] a, input pec_state_s s);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			`PEC_OFS_PATTERN: v = {30'h0, s.pattern};
			`PEC_OFS_RESPONSE: v = {29'h0, s.response};
			`PEC_OFS_FALL: v = {16'h0, s.fall_ms};
			`PEC_OFS_CMP_COND: v = {30'h0, s.cmp_cond};
			`PEC_OFS_CMP_THR: v = {17'h0, s.cmp_thr};
			`PEC_OFS_CLS_COND: v = {30'h0, s.cls_cond};
			`PEC_OFS_CLS_THR: v = {16'h0, s.cls_thr};
			`PEC_OFS_HOLD: v = {16'h0, s.hold_ms};
			`PEC_OFS_DO_CFG: v = {16'h0, s.do_cfg};
			`PEC_OFS_MONITOR: v = {26'h0, s.close, s.done, s.do_q};
			`PEC_OFS_ERROR: v = s.err;
			`PEC_OFS_IRQ_ST: v = {29'h0, s.irq_st};
			`PEC_OFS_IRQ_MASK: v = {29'h0, s.irq_mask};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a <= `PEC_OFS_IRQ_MASK) && (a[1:0] == 2'h0);
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < `PEC_N_DO; gi++) begin : g_do
			assign do_w[gi] = (d.do_cfg[gi*4 +: 4] == `PEC_FUNC_DONE) ? d.done :
				(d.do_cfg[gi*4 +: 4] == `PEC_FUNC_CLOSE) ? d.close : 1'b0;
		end
	endgenerate

	always_comb begin
		logic [31:0] old, mrg, abs_err;
		logic [2:0] w1c, ev;
		logic [15:0] mag;
		logic [47:0] lin, quad;
		logic in_pos, cmp_ok, cls_ok;
		d = q;
		w1c = 3'h0;
		mrg = 32'h0000_0000;
		old = 32'h0000_0000;
		abs_err = 32'h0000_0000;
		ev = 3'h0;
		mag = 16'h0000;
		lin = 48'h0;
		quad = 48'h0;
		in_pos = 1'b0;
		cmp_ok = 1'b0;
		cls_ok = 1'b0;
		// axi write channel, address and data in either order
		if (q.bvalid && s_axi_bready_i) begin
			d.bvalid = 1'b0;
		end
		if (q.awready && s_axi_awvalid_i) begin
			d.aw_got = 1'b1;
			d.aw_addr = s_axi_awaddr_i;
		end
		if (q.wready && s_axi_wvalid_i) begin
			d.w_got = 1'b1;
			d.w_data = s_axi_wdata_i;
			d.w_strb = s_axi_wstrb_i;
		end
		if (d.aw_got && d.w_got && !d.bvalid) begin
			old = reg_read(d.aw_addr, q);
			for (int i = 0; i < 4; i++) begin
				mrg[i*8 +: 8] = d.w_strb[i] ? d.w_data[i*8 +: 8] : old[i*8 +: 8];
			end
			unique case (d.aw_addr)
				`PEC_OFS_PATTERN: d.pattern = mrg[1:0];
				`PEC_OFS_RESPONSE: d.response = mrg[2:0];
				`PEC_OFS_FALL: d.fall_ms = mrg[15:0];
				`PEC_OFS_CMP_COND: d.cmp_cond = mrg[1:0];
				`PEC_OFS_CMP_THR: d.cmp_thr = mrg[14:0];
				`PEC_OFS_CLS_COND: d.cls_cond = mrg[1:0];
				`PEC_OFS_CLS_THR: d.cls_thr = mrg[15:0];
				`PEC_OFS_HOLD: d.hold_ms = mrg[15:0];
				`PEC_OFS_DO_CFG: d.do_cfg = mrg[15:0];
				`PEC_OFS_IRQ_ST: w1c = d.w_data[2:0] & {3{d.w_strb[0]}};
				`PEC_OFS_IRQ_MASK: d.irq_mask = mrg[2:0];
				default: d.bresp = `PEC_RESP_SLVERR;
			endcase
			d.bresp = mapped(d.aw_addr) ? `PEC_RESP_OKAY : `PEC_RESP_SLVERR;
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
		end
		// axi read channel
		if (q.rvalid && s_axi_rready_i) begin
			d.rvalid = 1'b0;
		end
		if (q.arready && s_axi_arvalid_i) begin
			d.rvalid = 1'b1;
			d.rdata = reg_read(s_axi_araddr_i, q);
			d.rresp = mapped(s_axi_araddr_i) ? `PEC_RESP_OKAY : `PEC_RESP_SLVERR;
		end
		d.awready = !d.aw_got && !d.bvalid;
		d.wready = !d.w_got && !d.bvalid;
		d.arready = !d.rvalid;

		// millisecond tick
		d.ms_tick = (q.ms_cnt == 32'(MS_CYCLES - 1));
		d.ms_cnt = d.ms_tick ? 32'h0 : q.ms_cnt + 32'h1;

		d.clr_in = error_clear_input_i;
		unique case (q.pattern)
			2'h0: clr_w = error_clear_input_i;
			2'h1: clr_w = error_clear_input_i && !q.clr_in;
			2'h2: clr_w = !error_clear_input_i;
			2'h3: clr_w = !error_clear_input_i && q.clr_in;
		endcase
		diff_w = pos_command_i - pos_feedback_i;
		if (clr_w) begin
			d.offset = diff_w;
		end
		d.err = diff_w - d.offset;

		// speed response after a clear
		mag = q.s0[15] ? 16'(-q.s0) : q.s0;
		lin = (48'(mag) * 48'(q.ramp_ms)) / 48'(q.ramp_f);
		quad = (48'(mag) * 48'(q.ramp_ms) * 48'(q.ramp_ms)) / (48'(q.ramp_f) * 48'(q.ramp_f));
		d.speed = speed_command_i;
		unique case (q.ramp)
			PEC_RAMP_IDLE: begin
				if (clr_w) begin
					unique case (q.response)
						3'h0: d.speed = 16'h0000;
						3'h4, 3'h6: begin
							if (q.fall_ms == 16'h0000) begin
								d.speed = 16'h0000;
							end else begin
								d.s0 = speed_command_i;
								d.ramp_f = q.fall_ms;
								d.ramp_ms = q.fall_ms;
								d.ramp = PEC_RAMP_RUN;
							end
						end
						default: d.speed = speed_command_i;
					endcase
				end
			end
			PEC_RAMP_RUN: begin
				d.speed = (q.response == 3'h6) ? 16'(quad) : 16'(lin);
				if (q.s0[15]) begin
					d.speed = 16'(-d.speed);
				end
				if (q.ms_tick) begin
					d.ramp_ms = q.ramp_ms - 16'h1;
					if (q.ramp_ms == 16'h1) begin
						d.ramp = PEC_RAMP_IDLE;
						d.speed = 16'h0000;
					end
				end
			end
		endcase

		abs_err = d.err[31] ? -d.err : d.err;
		in_pos = position_mode_i && running_i;
		cmp_ok = abs_err < {17'h0, q.cmp_thr};
		unique case (q.cmp_cond)
			2'h0: cmp_ok = cmp_ok;
			2'h1, 2'h3: cmp_ok = cmp_ok && (position_mode_speed_command_i == 16'h0000);
			2'h2: cmp_ok = cmp_ok && (filtered_position_speed_command_i == 16'h0000);
		endcase
		cls_ok = abs_err < {16'h0, q.cls_thr};
		unique case (q.cls_cond)
			2'h0: cls_ok = cls_ok;
			2'h1, 2'h3: cls_ok = cls_ok && (position_mode_speed_command_i == 16'h0000);
			2'h2: cls_ok = cls_ok && (filtered_position_speed_command_i == 16'h0000);
		endcase
		if (!in_pos || !cmp_ok) begin
			d.cmp_cnt = 16'h0;
		end else if (q.ms_tick && q.cmp_cnt != 16'hffff) begin
			d.cmp_cnt = q.cmp_cnt + 16'h1;
		end
		d.done = in_pos && cmp_ok && (d.cmp_cnt >= q.hold_ms);
		if (!in_pos || !cls_ok) begin
			d.cls_cnt = 16'h0;
		end else if (q.ms_tick && q.cls_cnt != 16'hffff) begin
			d.cls_cnt = q.cls_cnt + 16'h1;
		end
		d.close = in_pos && cls_ok && (d.cls_cnt >= q.hold_ms);
		d.do_q = do_w;

		// sticky events, set wins over clear
		ev = 3'h0;
		ev[`PEC_IRQ_CLEAR] = clr_w;
		ev[`PEC_IRQ_DONE] = d.done && !q.done;
		ev[`PEC_IRQ_CLOSE] = d.close && !q.close;
		d.irq_st = (q.irq_st & ~w1c) | ev;
		d.irq = |(d.irq_st & d.irq_mask);
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			q <= '0;
			q.cmp_thr <= `PEC_CMP_THR_RST;
			q.cls_thr <= `PEC_CLS_THR_RST;
			q.ramp <= PEC_RAMP_IDLE;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready_o = q.awready;
	assign s_axi_wready_o = q.wready;
	assign s_axi_bvalid_o = q.bvalid;
	assign s_axi_bresp_o = q.bresp;
	assign s_axi_arready_o = q.arready;
	assign s_axi_rvalid_o = q.rvalid;
	assign s_axi_rdata_o = q.rdata;
	assign s_axi_rresp_o = q.rresp;
	assign position_error_value_o = q.err;
	assign speed_out_o = q.speed;
	assign completed_o = q.done;
	assign close_o = q.close;
	assign do_terminal_o = q.do_q;
	assign irq_o = q.irq;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	err_calc_a: assert property (
		!clr_w |=> q.err == $past(diff_w) - $past(q.offset))
		else $error("error not command minus feedback");
	level_clear_a: assert property (
		q.pattern == 2'h2 && !error_clear_input_i |=> q.err == 32'h0)
		else $error("inactive level did not clear error");
	edge_clear_a: assert property (
		q.pattern == 2'h1 && error_clear_input_i && !q.clr_in |=> q.err == 32'h0)
		else $error("rising edge did not clear error");
	zero_speed_a: assert property (
		q.response == 3'h0 && q.ramp == PEC_RAMP_IDLE && clr_w |=> q.speed == 16'h0)
		else $error("speed not forced to zero");
	ramp_start_a: assert property (
		q.response == 3'h4 && q.ramp == PEC_RAMP_IDLE && clr_w && q.fall_ms != 16'h0
		|=> q.ramp == PEC_RAMP_RUN && q.ramp_ms == $past(q.fall_ms) ##1 q.ramp_ms <= $past(q.ramp_ms))
		else $error("linear ramp did not start");
	ramp_bound_a: assert property (
		q.ramp == PEC_RAMP_RUN && $past(q.ramp) == PEC_RAMP_RUN && !q.s0[15] |-> q.speed <= q.s0)
		else $error("ramp speed above start speed");
	done_hold_a: assert property (
		q.done |-> q.cmp_cnt >= $past(q.hold_ms))
		else $error("completed before hold time");
	close_mode_a: assert property (
		!(position_mode_i && running_i) |=> !q.close && q.cls_cnt == 16'h0)
		else $error("close outside position mode");
	do_route_a: assert property (
		q.do_cfg[3:0] == `PEC_FUNC_CLOSE |-> q.do_q[0] == q.close)
		else $error("close not routed to terminal");
	cond_speed_a: assert property (
		q.cmp_cond == 2'h3 && position_mode_speed_command_i != 16'h0 |=> !q.done)
		else $error("completed with nonzero speed");
	thr_reset_a: assert property (
		$fell(reset_i) |-> q.cmp_thr == `PEC_CMP_THR_RST)
		else $error("threshold reset value wrong");
	reserved_opt_a: assert property (
		q.response == 3'h5 && q.ramp == PEC_RAMP_IDLE && clr_w |=> q.ramp == PEC_RAMP_IDLE)
		else $error("reserved option started a ramp");
	irq_set_a: assert property (
		clr_w |=> q.irq_st[`PEC_IRQ_CLEAR])
		else $error("clear event lost");
	fall_clear_a: assert property (
		q.pattern == 2'h3 && !error_clear_input_i && q.clr_in |=> q.err == 32'h0)
		else $error("falling edge did not clear error");
	fall_zero_a: assert property (
		q.ramp == PEC_RAMP_IDLE && clr_w && (q.response == 3'h4 || q.response == 3'h6) && q.fall_ms == 16'h0 |=> q.speed == 16'h0)
		else $error("zero fall time did not stop speed");
	ramp_end_a: assert property (
		q.ramp == PEC_RAMP_RUN && q.ms_tick && q.ramp_ms == 16'h1 |=> q.ramp == PEC_RAMP_IDLE && q.speed == 16'h0)
		else $error("ramp did not end at zero");
	done_mode_a: assert property (
		!(position_mode_i && running_i) |=> !q.done && q.cmp_cnt == 16'h0)
		else $error("completed outside position mode");
	resp_hold_a: assert property (
		q.bvalid && !s_axi_bready_i |=> q.bvalid)
		else $error("write response dropped early");

endmodule // pec_error_clear

// >>> testbench/pec_host.sv
`timescale 1ns/10ps

module pec_host (
	input wire logic sys_clk_i,
	input wire logic clr_req_i,
	input wire logic [3:0] do_i,
	output logic clr_o,
	output int n_done_o
);
	logic last_q = 1'b0;
	int cnt_q = 0;

	assign n_done_o = cnt_q;

	// host drives clear line, counts done rises
	always @(posedge sys_clk_i) begin
		clr_o <= clr_req_i;
		last_q <= do_i[0];
		if (do_i[0] && !last_q)
			cnt_q <= cnt_q + 1;
	end
endmodule // pec_host

// >>> testbench/tb.sv
`timescale 1ns/10ps
`include "pec_defines.svh"

module tb import pec_pkg::*; ;
	localparam int MS = 10;
	localparam int H = 3;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] s_axi_awaddr_i = 8'h00;
	logic [7:0] s_axi_araddr_i = 8'h00;
	logic s_axi_awvalid_i = 1'b0;
	logic s_axi_wvalid_i = 1'b0;
	logic s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0;
	logic s_axi_rready_i = 1'b0;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic [31:0] pos_command_i = 32'h0;
	logic [31:0] pos_feedback_i = 32'h0;
	logic [15:0] speed_command_i = 16'h012c;
	logic [15:0] position_mode_speed_command_i = 16'h0;
	logic [15:0] filtered_position_speed_command_i = 16'h0;
	logic position_mode_i = 1'b0;
	logic running_i = 1'b0;
	logic clr_req = 1'b0;
	wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
	wire [31:0] s_axi_rdata_o, position_error_value_o;
	wire [15:0] speed_out_o;
	wire completed_o, close_o, irq_o, error_clear_input_i;
	wire [`PEC_N_DO-1:0] do_terminal_o;
	int n_done, n_errors = 0, num_checks = 0, cycles = 0, seed = 32'h2a6c, n, z;
	logic [31:0] off = 32'h0, rd;
	logic [1:0] rs;
	logic lv, hit;
	int vals[$];

	pec_error_clear #(.MS_CYCLES(MS)) dut (.*);
	pec_host host (.sys_clk_i(sys_clk_i), .clr_req_i(clr_req), .do_i(do_terminal_o),
		.clr_o(error_clear_input_i), .n_done_o(n_done));

	always #4 sys_clk_i = ~sys_clk_i;

	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		while (!(aw && w)) begin
			@(posedge sys_clk_i);
			if (s_axi_awready_o && !aw) begin
				aw = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (s_axi_wready_o && !w) begin
				w = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		do @(posedge sys_clk_i); while (!s_axi_bvalid_o);
		rs = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
		cyc(1);
	endtask

	task automatic rdr(input logic [7:0] a);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do @(posedge sys_clk_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge sys_clk_i); while (!s_axi_rvalid_o);
		rd = s_axi_rdata_o;
		rs = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
		cyc(1);
	endtask

	task automatic pulse(input logic act);
		clr_req <= act;
		cyc(1);
		clr_req <= !act;
		cyc(2);
		off = pos_command_i - pos_feedback_i;
	endtask

	task automatic se(input int e);
		pos_command_i <= pos_feedback_i + off + e;
	endtask

	initial begin
		pos_feedback_i = $random(seed);
		pos_command_i = pos_feedback_i;
		cyc(10);
		reset_i <= 1'b0;
		cyc(2);
		rdr(`PEC_OFS_CMP_THR);
		chk(rd, 32'h0000000a, "thr rst");
		rdr(`PEC_OFS_PATTERN);
		chk(rd, 32'h0, "pat rst");
		rdr(8'h40);
		chk(rd, 32'h0, "unmapped");
		chk(rs, `PEC_RESP_SLVERR, "rd resp");
		wr(8'h40, 32'hff);
		chk(rs, `PEC_RESP_SLVERR, "wr resp");
		pos_command_i <= pos_feedback_i + 32'h4d2;
		cyc(3);
		chk(position_error_value_o, 32'h4d2, "err");
		$display("regs done");
		for (int p = 0; p < 4; p++) begin
			lv = (p >= 2);
			clr_req <= lv;
			cyc(3);
			wr(`PEC_OFS_PATTERN, p);
			if (p == 2)
				off = pos_command_i - pos_feedback_i;
			pos_command_i <= pos_command_i + 7;
			cyc(3);
			chk(position_error_value_o, pos_command_i - pos_feedback_i - off, "idle");
			pulse(!lv);
			chk(position_error_value_o, 32'h0, "clear");
			chk(speed_out_o, 16'h0, "spd 0");
			pos_command_i <= pos_command_i + 3;
			cyc(3);
			chk(position_error_value_o, 32'h3, "back");
			chk(speed_out_o, speed_command_i, "spd");
		end
		rdr(`PEC_OFS_IRQ_ST);
		chk(rd, 32'h1, "st");
		chk(irq_o, 1'b0, "masked");
		wr(`PEC_OFS_IRQ_MASK, 32'h1);
		chk(rs, `PEC_RESP_OKAY, "wr ok");
		chk(irq_o, 1'b1, "irq");
		wr(`PEC_OFS_IRQ_ST, 32'h1);
		cyc(1);
		chk(irq_o, 1'b0, "w1c");
		$display("clear done");
		clr_req <= 1'b0;
		cyc(4);
		off = pos_command_i - pos_feedback_i;
		wr(`PEC_OFS_PATTERN, 32'h1);
		wr(`PEC_OFS_FALL, 32'h4);
		speed_command_i <= 16'h0190;
		for (int o = 4; o <= 6; o += 2) begin
			wr(`PEC_OFS_RESPONSE, o);
			vals.delete();
			for (int m = 0; m <= 4; m++)
				vals.push_back(o == 4 ? 100 * m : 25 * m * m);
			pulse(1'b1);
			z = 0;
			for (int i = 0; i < 70; i++) begin
				hit = 1'b0;
				foreach (vals[k])
					if (speed_out_o == vals[k])
						hit = 1'b1;
				z += (speed_out_o == 16'h0);
				chk(hit, 1'b1, "ramp");
				cyc(1);
			end
			chk({z > 0, speed_out_o}, {1'b1, 16'h0190}, "ramp end");
		end
		$display("ramp done");
		wr(`PEC_OFS_HOLD, H);
		wr(`PEC_OFS_CLS_THR, 32'h64);
		wr(`PEC_OFS_DO_CFG, 32'h21);
		se(5);
		cyc(40);
		chk(completed_o, 1'b0, "mode off");
		position_mode_i <= 1'b1;
		running_i <= 1'b1;
		se(50);
		cyc(H * MS + 5);
		chk({close_o, completed_o}, 2'b10, "band");
		se(5);
		n = 0;
		while (completed_o !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		chk(n >= (H - 1) * MS && n <= H * MS + 5, 1'b1, "hold");
		chk(do_terminal_o, 4'h3, "do");
		rdr(`PEC_OFS_MONITOR);
		chk(rd, 32'h33, "mon");
		chk(n_done, 1, "host");
		for (int c = 0; c < 4; c++) begin
			wr(`PEC_OFS_CMP_COND, c);
			position_mode_speed_command_i <= 16'h0;
			filtered_position_speed_command_i <= 16'h0;
			cyc(H * MS + 5);
			chk(completed_o, 1'b1, "cond");
			position_mode_speed_command_i <= 16'h5;
			cyc(4);
			chk(completed_o, c == 0 || c == 2, "pm spd");
			position_mode_speed_command_i <= 16'h0;
			filtered_position_speed_command_i <= 16'h5;
			cyc(4);
			chk(completed_o, c == 0, "flt spd");
		end
		se(-20);
		cyc(4);
		chk({close_o, completed_o}, 2'b10, "abs");
		position_mode_i <= 1'b0;
		cyc(4);
		chk(close_o, 1'b0, "mode");
		$display("pos done");
		stop_test();
	end
endmodule // tb
